// [core/accr_pkg.sv]
// Purpose: Shared constants and types for the channel calibration bank
// Assumes: Register words are 16 bits, one per 32-bit bus word
// Notes:   Printed offsets are word indexes; byte address is index times 4
`default_nettype none
package accr_pkg;
  // ---------------------------------------------------------------
  // Register indexes
  // ---------------------------------------------------------------
  localparam logic [5:0] IDX_CH1_CONFIG = 6'h0e;
  localparam logic [5:0] IDX_CH1_OFFSET_HIGH = 6'h0f;
  localparam logic [5:0] IDX_CH1_OFFSET_LOW = 6'h10;
  localparam logic [5:0] IDX_CH1_GAIN_HIGH = 6'h11;
  localparam logic [5:0] IDX_CH1_GAIN_LOW = 6'h12;
  localparam logic [5:0] IDX_CH2_CONFIG = 6'h13;
  localparam logic [5:0] IDX_CH2_OFFSET_HIGH = 6'h14;
  localparam logic [5:0] IDX_CH2_OFFSET_LOW = 6'h15;
  localparam logic [5:0] IDX_CH2_GAIN_HIGH = 6'h16;
  localparam logic [5:0] IDX_CH2_GAIN_LOW = 6'h17;
  localparam logic [5:0] IDX_FIRST = 6'h0e;
  localparam int NUM_CH = 2;
  localparam int WORDS_PER_CH = 5;
  // ---------------------------------------------------------------
  // Field positions and masks
  // ---------------------------------------------------------------
  localparam int PHASE_LSB = 6;
  localparam int DCOFF_BIT = 2;
  localparam logic [15:0] CFG_WMASK = 16'hffc7;
  localparam logic [15:0] LOW_WMASK = 16'hff00;
  localparam logic [15:0] FULL_WMASK = 16'hffff;
  // ---------------------------------------------------------------
  // Reset values and bus response codes
  // ---------------------------------------------------------------
  localparam logic [15:0] RST_CONFIG = 16'h0000;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [15:0] RST_GAIN_HIGH = 16'h8000;
  localparam logic [15:0] RST_GAIN_LOW = 16'h0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Per channel settings handed to the datapath
  typedef struct packed {
    logic [9:0] phase_delay;
    logic dc_filter_off;
    logic [1:0] input_select;
    logic [23:0] offset;
    logic [23:0] gain;
  } accr_chan_t;
endpackage : accr_pkg
`default_nettype wire

// [core/accr_regs.sv]
// Purpose: Channel 1 and 2 configuration and calibration registers
// Assumes: AXI4-Lite slave, one read and one write in flight at most
// Notes:   Unmapped addresses answer SLVERR, read data zero
//
// Contract
// RL1 - Config bits 15:6 hold a signed 10-bit phase delay.
// RL2 - Config bits 5:3 always read zero.
// RL3 - Config bit 2 turns the channel DC filter off when set.
// RL4 - Config bits 1:0 select the channel input source.
// RL5 - Offset is 24-bit, upper 16 in high word, low 8 in low word 15:8.
// RL6 - Bits 7:0 of offset low and gain low words read zero.
// RL7 - Gain is 24-bit unsigned, upper 16 bits in gain high word.
// RL8 - Gain low 8 bits sit in bits 15:8 of the writable gain low word.
// RL9 - Gain high word resets to 8000h, gain low word to zero.
// RL10 - Offset and config words reset to zero.
// RL11 - Channel 2 config uses the channel 1 layout, 00 by default.
// RL12 - Channel 2 config sits at index 13h, its offset high at 14h.
// RL13 - Writes to read-only bits are ignored and they still read zero.
//
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none
module accr_regs (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // Write address and data
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  // Write response
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  // Read address
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  // Read data
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I,
  // Channel settings
  output accr_pkg::accr_chan_t CH1_O,
  output accr_pkg::accr_chan_t CH2_O
);
  // Ten 16-bit words, config first in each channel's group of five
  localparam int NW = accr_pkg::NUM_CH * accr_pkg::WORDS_PER_CH;

  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic awready;
    logic wready;
    logic arready;
    logic [NW-1:0][15:0] word;
  } accr_state_t;

  accr_state_t cur_ff;
  accr_state_t nxt_ff;

  // -----------------------------------------------------------------
  // Decode helpers
  // -----------------------------------------------------------------
  // Byte address to word slot; valid flag in bit 4
  function automatic logic [4:0] slot_of(input logic [7:0] a);
    logic [5:0] idx;
    logic [5:0] rel;
    idx = a[7:2];
    rel = idx - accr_pkg::IDX_FIRST;
    if (a[1:0] == 2'h0 && idx >= accr_pkg::IDX_FIRST && rel < 6'(NW)) begin
      slot_of = {1'b1, rel[3:0]};
    end else begin
      slot_of = 5'h00;
    end
  endfunction : slot_of

  // Writable bits of each word slot
  function automatic logic [15:0] wmask_of(input logic [3:0] s);
    logic [3:0] k;
    k = (s >= 4'(accr_pkg::WORDS_PER_CH)) ?
        4'(s - 4'(accr_pkg::WORDS_PER_CH)) : s;
    case (k)
      4'h0: wmask_of = accr_pkg::CFG_WMASK; // [RL2] [RL11]
      4'h2: wmask_of = accr_pkg::LOW_WMASK; // [RL6] [RL5]
      4'h4: wmask_of = accr_pkg::LOW_WMASK; // [RL6] [RL8]
      default: wmask_of = accr_pkg::FULL_WMASK;
    endcase
  endfunction : wmask_of

  // Reset value of each word slot
  function automatic logic [15:0] rst_of(input int s);
    case (s % accr_pkg::WORDS_PER_CH)
      0: rst_of = accr_pkg::RST_CONFIG; // [RL10]
      1: rst_of = accr_pkg::RST_OFFSET; // [RL10]
      2: rst_of = accr_pkg::RST_OFFSET; // [RL10]
      3: rst_of = accr_pkg::RST_GAIN_HIGH; // [RL9]
      default: rst_of = accr_pkg::RST_GAIN_LOW; // [RL9]
    endcase
  endfunction : rst_of

  logic [4:0] wslot;
  logic [4:0] rslot;
  logic [15:0] wmask;
  logic [15:0] lane_mask;
  // Write side decodes the held address, read side the live one
  assign wslot = slot_of(cur_ff.awaddr);
  assign rslot = slot_of(ARADDR_I);
  assign wmask = wmask_of(wslot[3:0]);
  assign lane_mask = {{8{cur_ff.wstrb[1]}}, {8{cur_ff.wstrb[0]}}};

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  // Write commits once address and data are both held and no response
  // is pending, so a stalled bready simply holds off the next write.
  always_comb begin
    logic do_wr;
    do_wr = 1'b0;
    nxt_ff = cur_ff;
    if (AWVALID_I && cur_ff.awready) begin
      nxt_ff.aw_got = 1'b1;
      nxt_ff.awaddr = AWADDR_I;
    end
    if (WVALID_I && cur_ff.wready) begin
      nxt_ff.w_got = 1'b1;
      nxt_ff.wdata = WDATA_I;
      nxt_ff.wstrb = WSTRB_I;
    end
    if (cur_ff.bvalid && BREADY_I) begin
      nxt_ff.bvalid = 1'b0;
    end
    do_wr = cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid;
    if (do_wr) begin
      nxt_ff.aw_got = 1'b0;
      nxt_ff.w_got = 1'b0;
      nxt_ff.bvalid = 1'b1;
      nxt_ff.bresp = wslot[4] ? accr_pkg::RESP_OKAY : accr_pkg::RESP_SLVERR;
      if (wslot[4]) begin
        // Read-only bits keep their zero whatever is written
        nxt_ff.word[wslot[3:0]] = (cur_ff.word[wslot[3:0]] &
                                   ~(wmask & lane_mask)) |
                                  (cur_ff.wdata[15:0] & wmask &
                                   lane_mask); // [RL13] [RL12]
      end
    end
    // Read path
    if (cur_ff.rvalid && RREADY_I) begin
      nxt_ff.rvalid = 1'b0;
    end
    if (ARVALID_I && cur_ff.arready) begin
      nxt_ff.rvalid = 1'b1;
      nxt_ff.rresp = rslot[4] ? accr_pkg::RESP_OKAY : accr_pkg::RESP_SLVERR;
      nxt_ff.rdata = rslot[4] ?
                     {16'h0000, cur_ff.word[rslot[3:0]]} : 32'h0000_0000;
    end
    if (RST_I) begin
      nxt_ff = '0;
      for (int i = 0; i < NW; i++) begin
        nxt_ff.word[i] = rst_of(i); // [RL9] [RL10]
      end
    end
    // Readiness is registered so no bus output passes through gates;
    // it is worked out from the next state, so it never lags a handshake
    nxt_ff.awready = !nxt_ff.aw_got && !nxt_ff.bvalid;
    nxt_ff.wready = !nxt_ff.w_got && !nxt_ff.bvalid;
    nxt_ff.arready = !nxt_ff.rvalid;
  end

  // State register
  always_ff @(posedge CORE_CLK_I) begin
    cur_ff <= nxt_ff;
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  // Every bus output is a flop of the state word, no gates in between
  assign AWREADY_O = cur_ff.awready;
  assign WREADY_O = cur_ff.wready;
  assign ARREADY_O = cur_ff.arready;
  assign BVALID_O = cur_ff.bvalid;
  assign BRESP_O = cur_ff.bresp;
  assign RVALID_O = cur_ff.rvalid;
  assign RRESP_O = cur_ff.rresp;
  assign RDATA_O = cur_ff.rdata;

  // Unpack words into per channel fields
  accr_pkg::accr_chan_t chan [accr_pkg::NUM_CH];
  genvar g;
  generate
    for (g = 0; g < accr_pkg::NUM_CH; g++) begin : g_ch
      localparam int B = g * accr_pkg::WORDS_PER_CH;
      assign chan[g].phase_delay =
        cur_ff.word[B][15:accr_pkg::PHASE_LSB]; // [RL1]
      assign chan[g].dc_filter_off =
        cur_ff.word[B][accr_pkg::DCOFF_BIT]; // [RL3]
      assign chan[g].input_select = cur_ff.word[B][1:0]; // [RL4] [RL11]
      assign chan[g].offset =
        {cur_ff.word[B+1], cur_ff.word[B+2][15:8]}; // [RL5]
      assign chan[g].gain =
        {cur_ff.word[B+3], cur_ff.word[B+4][15:8]}; // [RL7] [RL8]
    end
  endgenerate
  assign CH1_O = chan[0];
  assign CH2_O = chan[1];

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  // Read address taken at one byte address
  sequence s_rd(logic [7:0] a);
    ARVALID_I && ARREADY_O && ARADDR_I == a;
  endsequence

  // Held write commits this cycle into one slot; bit 4 is the hit flag
  sequence s_commit(logic [4:0] s);
    cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid && wslot == s;
  endsequence

  // Held write enables both byte lanes of the register word
  sequence s_both_lanes;
    cur_ff.wstrb[1:0] == 2'h3;
  endsequence

  // Any read address taken this cycle
  sequence s_rd_any;
    ARVALID_I && ARREADY_O;
  endsequence

  // Reserved channel 2 config bits read back as zero
  AST_CFG_RSV_ZERO: assert property ( // [RL2]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_rd({accr_pkg::IDX_CH2_CONFIG, 2'h0}) |=> RDATA_O[5:3] == 3'h0)
    else $error("config reserved bits not zero");

  // Reserved low byte of a gain low word reads as zero
  AST_LOW_RSV_ZERO: assert property ( // [RL6]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_rd({accr_pkg::IDX_CH1_GAIN_LOW, 2'h0}) |=> RDATA_O[7:0] == 8'h00)
    else $error("low word reserved byte not zero");

  // Same for the channel 2 offset low word
  AST_CH2_LOW_RSV: assert property ( // [RL6]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_rd({accr_pkg::IDX_CH2_OFFSET_LOW, 2'h0}) |=> RDATA_O[7:0] == 8'h00)
    else $error("channel 2 low word reserved byte not zero");

  // Unity gain on both channels at the first edge after reset
  AST_GAIN_RST: assert property ( // [RL9]
    @(posedge CORE_CLK_I)
    $fell(RST_I) |-> CH1_O.gain == 24'h800000
      && CH2_O.gain == 24'h800000)
    else $error("gain not unity after reset");

  // Config and offset fields clear at the first edge after reset
  AST_CFG_RST: assert property ( // [RL10]
    @(posedge CORE_CLK_I)
    $fell(RST_I) |-> CH1_O.phase_delay == 10'h000 && !CH2_O.dc_filter_off
      && CH2_O.input_select == 2'h0 && CH1_O.offset == 24'h000000)
    else $error("config or offset not zero after reset");

  // A write held on both channels is answered at the next edge
  AST_WR_RESP: assert property ( // [RL13]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid |=> BVALID_O)
    else $error("write not answered");

  // Channel 2 offset high answers from its own slot
  AST_RD_RESP: assert property ( // [RL12]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_rd({accr_pkg::IDX_CH2_OFFSET_HIGH, 2'h0}) |=>
      RVALID_O && RRESP_O == accr_pkg::RESP_OKAY
      && RDATA_O[15:0] == $past(cur_ff.word[6]))
    else $error("offset high read mismatch");

  // Only the low half of the read word carries a register
  AST_RD_UPPER_ZERO: assert property ( // [RL12]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_rd_any |=> RVALID_O && RDATA_O[31:16] == 16'h0000)
    else $error("read upper half not zero");

  // Offset and gain words join into the 24-bit values
  AST_OFS_PACK: assert property ( // [RL5] [RL7]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    CH1_O.offset[7:0] == cur_ff.word[2][15:8]
      && CH2_O.gain[23:8] == cur_ff.word[8])
    else $error("offset or gain packing wrong");

  // Config fields sit where the layout puts them
  AST_PHASE_MAP: assert property ( // [RL1] [RL4]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    CH2_O.phase_delay == cur_ff.word[5][15:6]
      && CH1_O.input_select == cur_ff.word[0][1:0])
    else $error("config field map wrong");

  // A full write to channel 1 config lands in its three fields
  AST_CHANNEL1_CONFIG_STORE: assert property ( // [RL1] [RL3] [RL4]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_commit(5'h10) ##0 s_both_lanes |=>
      CH1_O.phase_delay == $past(cur_ff.wdata[15:6])
      && CH1_O.dc_filter_off == $past(cur_ff.wdata[2])
      && CH1_O.input_select == $past(cur_ff.wdata[1:0]))
    else $error("channel 1 config write not applied");

  // Offset low byte comes from bits 15:8 and 7:0 stays clear
  AST_CH1_OFS_LOW: assert property ( // [RL5] [RL6]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_commit(5'h12) ##0 s_both_lanes |=>
      CH1_O.offset[7:0] == $past(cur_ff.wdata[15:8])
      && cur_ff.word[2][7:0] == 8'h00)
    else $error("channel 1 offset low write wrong");

  // Gain low byte comes from bits 15:8 of its writable word
  AST_CH1_GAIN_LOW: assert property ( // [RL8]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_commit(5'h14) ##0 s_both_lanes |=>
      CH1_O.gain[7:0] == $past(cur_ff.wdata[15:8])
      && CH1_O.gain[23:8] == $past(cur_ff.word[3]))
    else $error("channel 1 gain low write wrong");

  // Channel 2 config at 13h follows the channel 1 layout
  AST_CHANNEL2_CONFIG_STORE: assert property ( // [RL11] [RL12]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    s_commit(5'h15) ##0 s_both_lanes |=>
      CH2_O.phase_delay == $past(cur_ff.wdata[15:6])
      && CH2_O.dc_filter_off == $past(cur_ff.wdata[2])
      && CH2_O.input_select == $past(cur_ff.wdata[1:0]))
    else $error("channel 2 config write not applied");

  // Read-only positions stay zero in storage whatever was written
  AST_RSV_STORED_ZERO: assert property ( // [RL13]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    cur_ff.word[0][5:3] == 3'h0 && cur_ff.word[5][5:3] == 3'h0
      && cur_ff.word[2][7:0] == 8'h00 && cur_ff.word[4][7:0] == 8'h00
      && cur_ff.word[7][7:0] == 8'h00 && cur_ff.word[9][7:0] == 8'h00)
    else $error("read-only bits hold a one");

  // A write that misses every slot stores nothing and answers an error
  AST_UNMAPPED_KEEP: assert property ( // [RL12]
    @(posedge CORE_CLK_I) disable iff (RST_I)
    cur_ff.aw_got && cur_ff.w_got && !cur_ff.bvalid && !wslot[4] |=>
      $stable(cur_ff.word) && BRESP_O == accr_pkg::RESP_SLVERR)
    else $error("unmapped write changed storage");
endmodule : accr_regs
`default_nettype wire

// [verif/tb_top.sv]
// Purpose: Self-checking bench for the channel calibration register bank
// Assumes: AXI4-Lite master tasks, word index times 4 is the byte address
// Notes:   Only mismatches and the verdict are printed
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] aw_a = 8'h00;
  logic [7:0] ar_a = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'h0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic bry = 1'b0;
  logic rry = 1'b0;
  logic aw_rdy, w_rdy, ar_rdy, bv, rv;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  accr_pkg::accr_chan_t ch1, ch2;
  int bad_count = 0;
  int n_checks = 0;
  logic [5:0] i;

  accr_regs dut_u (.CORE_CLK_I(clk), .RST_I(rst), .AWADDR_I(aw_a),
    .AWVALID_I(awv), .AWREADY_O(aw_rdy), .WDATA_I(wd), .WSTRB_I(ws),
    .WVALID_I(wv), .WREADY_O(w_rdy), .BRESP_O(bresp), .BVALID_O(bv),
    .BREADY_I(bry), .ARADDR_I(ar_a), .ARVALID_I(arv), .ARREADY_O(ar_rdy),
    .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rv), .RREADY_I(rry),
    .CH1_O(ch1), .CH2_O(ch2));

  // ----------------------------------------------------------------
  // Clock, verdict and watchdog
  // ----------------------------------------------------------------
  initial begin
    forever #25 clk = ~clk;
  end

  task automatic wrap_up;
    if (bad_count == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up

  // Whole run is a few hundred cycles, so this limit only cuts a hang
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Each bus task lets one edge pass at its end so strobes never toggle twice
  task automatic wr(input logic [5:0] idx, input logic [15:0] d,
                    input logic [3:0] st, input logic [1:0] er);
    int n;
    n = 0;
    aw_a <= {idx, 2'h0};
    wd <= {16'h0, d};
    ws <= st;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (aw_rdy === 1'b1) awv <= 1'b0;
      if (w_rdy === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 40);
    bry <= 1'b0;
    chk("bwait", 32'h1, 32'(n < 40));
    chk("bresp", 32'(er), 32'(bresp));
    @(posedge clk);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [15:0] ed,
                    input logic [1:0] er);
    int n;
    n = 0;
    ar_a <= {idx, 2'h0};
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (ar_rdy === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 40);
    rry <= 1'b0;
    chk("rwait", 32'h1, 32'(n < 40));
    chk("rdata", {16'h0, ed}, rdata);
    chk("rresp", 32'(er), 32'(rresp));
    @(posedge clk);
  endtask : rd

  // Reset image: gain high words hold unity, all else clear
  function automatic logic [15:0] rst_val(input logic [5:0] x);
    return (x == 6'h11 || x == 6'h16) ? 16'h8000 : 16'h0000;
  endfunction : rst_val

  // Readable bits: config loses 5:3, low words lose 7:0
  function automatic logic [15:0] rd_mask(input logic [5:0] x);
    if (x == 6'h0e || x == 6'h13) return 16'hffc7;
    if (x == 6'h10 || x == 6'h12 || x == 6'h15 || x == 6'h17) return 16'hff00;
    return 16'hffff;
  endfunction : rd_mask

  task automatic rst_pulse;
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask : rst_pulse

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst_pulse();
    for (i = 6'h0e; i <= 6'h17; i++) rd(i, rst_val(i), 2'h0);
    chk("g1", 32'h800000, 32'(ch1.gain));
    chk("g2", 32'h800000, 32'(ch2.gain));
    // All ones must leave the reserved bits clear
    for (i = 6'h0e; i <= 6'h17; i++) wr(i, 16'hffff, 4'hf, 2'h0);
    for (i = 6'h0e; i <= 6'h17; i++) rd(i, rd_mask(i), 2'h0);
    chk("o2", 32'hffffff, 32'(ch2.offset));
    chk("g2", 32'hffffff, 32'(ch2.gain));
    // Distinct patterns expose field placement
    wr(6'h0e, 16'h8042, 4'hf, 2'h0);
    chk("p1", 32'h201, 32'(ch1.phase_delay));
    chk("d1", 32'h0, 32'(ch1.dc_filter_off));
    chk("s1", 32'h2, 32'(ch1.input_select));
    wr(6'h0f, 16'h1234, 4'hf, 2'h0);
    wr(6'h10, 16'h56ff, 4'hf, 2'h0);
    chk("o1", 32'h123456, 32'(ch1.offset));
    wr(6'h11, 16'h9abc, 4'hf, 2'h0);
    wr(6'h12, 16'hde00, 4'hf, 2'h0);
    chk("g1", 32'h9abcde, 32'(ch1.gain));
    rd(6'h12, 16'hde00, 2'h0);
    // Byte strobes keep the byte whose lane is off
    wr(6'h0f, 16'h5555, 4'h1, 2'h0);
    rd(6'h0f, 16'h1255, 2'h0);
    wr(6'h0f, 16'haaaa, 4'h2, 2'h0);
    rd(6'h0f, 16'haa55, 2'h0);
    chk("o1", 32'haa5556, 32'(ch1.offset));
    // Every input source code on channel 2
    for (int c = 0; c < 4; c++) begin
      wr(6'h13, 16'(c) | 16'hffc0, 4'hf, 2'h0);
      chk("s2", 32'(c), 32'(ch2.input_select));
      chk("d2", 32'h0, 32'(ch2.dc_filter_off));
      chk("p2", 32'h3ff, 32'(ch2.phase_delay));
    end
    wr(6'h13, 16'h0004, 4'hf, 2'h0);
    chk("d2", 32'h1, 32'(ch2.dc_filter_off));
    rd(6'h13, 16'h0004, 2'h0);
    wr(6'h14, 16'h00a5, 4'hf, 2'h0);
    chk("o2", 32'h00a5ff, 32'(ch2.offset));
    // Unmapped places answer with an error and store nothing
    wr(6'h20, 16'hbeef, 4'hf, 2'h2);
    rd(6'h10, 16'h5600, 2'h0);
    rd(6'h20, 16'h0000, 2'h2);
    rd(6'h0d, 16'h0000, 2'h2);
    // Second reset in mid-run restores the reset image
    rst_pulse();
    for (i = 6'h0e; i <= 6'h17; i++) rd(i, rst_val(i), 2'h0);
    chk("s2", 32'h0, 32'(ch2.input_select));
    chk("g2", 32'h800000, 32'(ch2.gain));
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
